//--- include/ftg_pkg.sv
// Shared constants and types for the frame trigger generator block.
package ftg_pkg;

    // Bus and datapath widths.
    localparam int unsigned DATA_W = 32;
    localparam int unsigned ADR_W  = 8;
    localparam int unsigned DIV_W  = 16;
    localparam int unsigned CNT_W  = 16;
    localparam int unsigned SEL_W  = 4;

    // Register byte offsets.
    localparam logic [7:0] REG_CTRL     = 8'h00;
    localparam logic [7:0] REG_DIV_ONE  = 8'h04;
    localparam logic [7:0] REG_DIV_TWO  = 8'h08;
    localparam logic [7:0] REG_INTERVAL = 8'h0C;
    localparam logic [7:0] REG_COUNT    = 8'h10;
    localparam logic [7:0] REG_ROUTE    = 8'h14;
    localparam logic [7:0] REG_STATUS   = 8'h18;

    // Control register fields.
    localparam int unsigned CTL_W          = 5;
    localparam int unsigned CTL_GEN_ONE_EN = 0;
    localparam int unsigned CTL_GEN_TWO_EN = 1;
    localparam int unsigned CTL_FRAME_EN   = 2;
    localparam int unsigned CTL_FRAME_ASSC = 3;
    localparam int unsigned CTL_CONTINUOUS = 4;

    // Routing register fields, one group of four bits per signal.
    localparam int unsigned RT_W         = 14;
    localparam int unsigned RT_STRIDE    = 4;
    localparam int unsigned RT_SRC_IO    = 0;
    localparam int unsigned RT_IN_REAR   = 1;
    localparam int unsigned RT_DRV_FRONT = 2;
    localparam int unsigned RT_DRV_REAR  = 3;
    localparam int unsigned RT_AD_SEL    = 12;
    localparam int unsigned RT_DA_SEL    = 13;

    // Signal indices of the three conversion-control lines.
    localparam int unsigned SIG_N     = 3;
    localparam int unsigned SIG_ONE   = 0;
    localparam int unsigned SIG_TWO   = 1;
    localparam int unsigned SIG_FRAME = 2;

    // Status register fields.
    localparam int unsigned ST_BUSY       = 0;
    localparam int unsigned ST_DONE       = 1;
    localparam int unsigned ST_LEVEL_LSB  = 2;
    localparam int unsigned ST_ISSUED_LSB = 16;

    // Reset values.
    localparam logic [CTL_W-1:0] CTRL_RST     = 5'h00;
    localparam logic [DIV_W-1:0] DIV_RST      = 16'h0064;
    localparam logic [CNT_W-1:0] INTERVAL_RST = 16'h0004;
    localparam logic [CNT_W-1:0] COUNT_RST    = 16'h0001;
    localparam logic [RT_W-1:0]  ROUTE_RST    = 14'h0000;

    // Frame generator sequence states.
    typedef enum logic [1:0] {
        FTG_IDLE,
        FTG_RUN,
        FTG_DONE
    } ftg_state_t;

endpackage

//--- rtl/ftg_pin_io.sv
// One bidirectional conversion-control signal on a front line and a rear pin.
`timescale 1ns/1ps

module ftg_pin_io (
    input  wire logic i_clk,
    input  wire logic i_reset_n,
    input  wire logic i_gen,
    input  wire logic i_drive_front,
    input  wire logic i_drive_rear,
    input  wire logic i_in_rear,
    input  wire logic i_front_in,
    output logic      o_front_out,
    output logic      o_front_oe,
    input  wire logic i_rear_in,
    output logic      o_rear_out,
    output logic      o_rear_oe,
    output logic      o_in
);

    typedef struct packed {
        logic front_s1;
        logic front_s2;
        logic rear_s1;
        logic rear_s2;
        logic front_out;
        logic front_oe;
        logic rear_out;
        logic rear_oe;
        logic in_lvl;
    } ftg_pin_state_t;

    ftg_pin_state_t s_q;
    ftg_pin_state_t s_d;

    // Receivers are synchronised and always sampled, driven or not, so a line
    // this card drives can be looped back as its own input.
    always_comb begin
        s_d           = s_q;
        s_d.front_s1  = i_front_in;
        s_d.front_s2  = s_q.front_s1;
        s_d.rear_s1   = i_rear_in;
        s_d.rear_s2   = s_q.rear_s1;
        s_d.in_lvl    = i_in_rear ? s_q.rear_s2 : s_q.front_s2;
        s_d.front_out = i_gen;
        s_d.rear_out  = i_gen;
        s_d.front_oe  = i_drive_front;
        s_d.rear_oe   = i_drive_rear;
    end

    // State register; drivers come up released so nothing fights the bus.
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign o_front_out = s_q.front_out;
    assign o_front_oe  = s_q.front_oe;
    assign o_rear_out  = s_q.rear_out;
    assign o_rear_oe   = s_q.rear_oe;
    assign o_in        = s_q.in_lvl;

endmodule // ftg_pin_io

//--- rtl/ftg_top.sv
// Frame trigger generator with conversion clock generators and signal routing.
//
// Local design decisions: the Wishbone register port and the placing of the registers.
`timescale 1ns/1ps

module ftg_top (
    input  wire logic                         i_clk,
    input  wire logic                         i_reset_n,
    input  wire logic                         i_wb_cyc,
    input  wire logic                         i_wb_stb,
    input  wire logic                         i_wb_we,
    input  wire logic [ftg_pkg::ADR_W-1:0]    i_wb_adr,
    input  wire logic [ftg_pkg::SEL_W-1:0]    i_wb_sel,
    input  wire logic [ftg_pkg::DATA_W-1:0]   i_wb_dat,
    output logic      [ftg_pkg::DATA_W-1:0]   o_wb_dat,
    output logic                              o_wb_ack,
    input  wire logic [ftg_pkg::SIG_N-1:0]    i_front_in,
    output logic      [ftg_pkg::SIG_N-1:0]    o_front_out,
    output logic      [ftg_pkg::SIG_N-1:0]    o_front_oe,
    input  wire logic [ftg_pkg::SIG_N-1:0]    i_rear_in,
    output logic      [ftg_pkg::SIG_N-1:0]    o_rear_out,
    output logic      [ftg_pkg::SIG_N-1:0]    o_rear_oe,
    output logic                              o_conversion_rate_line_one,
    output logic                              o_conversion_rate_line_two,
    output logic                              o_frame_start_line_n,
    output logic                              o_frame_event,
    output logic                              o_ad_conv_clk,
    output logic                              o_da_conv_clk
);

    typedef struct packed {
        logic [ftg_pkg::CTL_W-1:0]  ctrl;
        logic [ftg_pkg::DIV_W-1:0]  div_one;
        logic [ftg_pkg::DIV_W-1:0]  div_two;
        logic [ftg_pkg::CNT_W-1:0]  interval;
        logic [ftg_pkg::CNT_W-1:0]  count;
        logic [ftg_pkg::RT_W-1:0]   route;
        logic [ftg_pkg::DIV_W-1:0]  g1_cnt;
        logic [ftg_pkg::DIV_W-1:0]  g2_cnt;
        logic                       g1_lvl;
        logic                       g2_lvl;
        logic                       assoc_prev;
        ftg_pkg::ftg_state_t        state;
        logic [ftg_pkg::CNT_W-1:0]  ivl_cnt;
        logic [ftg_pkg::CNT_W-1:0]  issued;
        logic                       pulse_act;
        logic                       frame_out;
        logic                       conv_one;
        logic                       conv_two;
        logic                       frame_sig;
        logic                       frame_prev;
        logic                       frame_evt;
        logic                       ad_clk;
        logic                       da_clk;
        logic                       ack;
        logic [ftg_pkg::DATA_W-1:0] rdat;
    } ftg_state_q_t;

    ftg_state_q_t s_q;
    ftg_state_q_t s_d;

    logic [ftg_pkg::SIG_N-1:0] pin_in;
    logic [ftg_pkg::SIG_N-1:0] gen_lvl;

    // Half-period divider step, shared by both conversion clock generators.
    // Returns the next level in the top bit and the next count below it.
    function automatic logic [ftg_pkg::DIV_W:0] gen_step(
        input logic                      en,
        input logic [ftg_pkg::DIV_W-1:0] div,
        input logic [ftg_pkg::DIV_W-1:0] cnt,
        input logic                      lvl
    );
        logic [ftg_pkg::DIV_W:0] r;
        r = '0;
        if (!en) begin
            r = '0;
        end else if ((div == '0) || (cnt >= (div - 16'h0001))) begin
            r = {~lvl, {ftg_pkg::DIV_W{1'b0}}};
        end else begin
            r = {lvl, cnt + 16'h0001};
        end
        return r;
    endfunction

    // Byte-lane merge of a bus write into a register image.
    function automatic logic [ftg_pkg::DATA_W-1:0] lane_merge(
        input logic [ftg_pkg::DATA_W-1:0] old_v,
        input logic [ftg_pkg::DATA_W-1:0] wdat,
        input logic [ftg_pkg::SEL_W-1:0]  sel
    );
        logic [ftg_pkg::DATA_W-1:0] r;
        r = old_v;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                r[b*8 +: 8] = wdat[b*8 +: 8];
            end
        end
        return r;
    endfunction

    // Next-state logic: bus slave, generators, frame sequence and routing.
    always_comb begin
        logic                       access;
        logic [ftg_pkg::DIV_W:0]    step1;
        logic [ftg_pkg::DIV_W:0]    step2;
        logic                       assoc_lvl;
        logic                       assoc_evt;
        logic                       frame_en;
        logic                       cont;
        logic [ftg_pkg::DATA_W-1:0] st;
        access    = 1'b0;
        step1     = '0;
        step2     = '0;
        assoc_lvl = 1'b0;
        assoc_evt = 1'b0;
        frame_en  = 1'b0;
        cont      = 1'b0;
        st        = '0;
        s_d       = s_q;

        // Classic single-cycle slave: ack follows the request by one cycle,
        // and a write lands on the edge at which the master sees ack high.
        access = i_wb_cyc && i_wb_stb && !s_q.ack;
        s_d.ack = access;
        if (s_q.ack && i_wb_cyc && i_wb_stb && i_wb_we) begin
            if (i_wb_adr == ftg_pkg::REG_CTRL) begin
                s_d.ctrl = ftg_pkg::CTL_W'(lane_merge(32'(s_q.ctrl), i_wb_dat, i_wb_sel));
            end else if (i_wb_adr == ftg_pkg::REG_DIV_ONE) begin
                s_d.div_one = ftg_pkg::DIV_W'(lane_merge(32'(s_q.div_one), i_wb_dat, i_wb_sel));
            end else if (i_wb_adr == ftg_pkg::REG_DIV_TWO) begin
                s_d.div_two = ftg_pkg::DIV_W'(lane_merge(32'(s_q.div_two), i_wb_dat, i_wb_sel));
            end else if (i_wb_adr == ftg_pkg::REG_INTERVAL) begin
                s_d.interval = ftg_pkg::CNT_W'(lane_merge(32'(s_q.interval), i_wb_dat,
                                                          i_wb_sel));
            end else if (i_wb_adr == ftg_pkg::REG_COUNT) begin
                s_d.count = ftg_pkg::CNT_W'(lane_merge(32'(s_q.count), i_wb_dat,
                                                       i_wb_sel));
            end else if (i_wb_adr == ftg_pkg::REG_ROUTE) begin
                s_d.route = ftg_pkg::RT_W'(lane_merge(32'(s_q.route), i_wb_dat, i_wb_sel));
            end
        end

        // Status image shows the sequence state, the line levels and pulses issued.
        st[ftg_pkg::ST_BUSY] = (s_q.state == ftg_pkg::FTG_RUN);
        st[ftg_pkg::ST_DONE] = (s_q.state == ftg_pkg::FTG_DONE);
        st[ftg_pkg::ST_LEVEL_LSB +: 3] = {s_q.frame_sig, s_q.conv_two, s_q.conv_one};
        st[ftg_pkg::ST_ISSUED_LSB +: ftg_pkg::CNT_W] = s_q.issued;

        // Read data is captured with ack; unmapped offsets read zero.
        if (access) begin
            if (i_wb_adr == ftg_pkg::REG_CTRL) begin
                s_d.rdat = 32'(s_q.ctrl);
            end else if (i_wb_adr == ftg_pkg::REG_DIV_ONE) begin
                s_d.rdat = 32'(s_q.div_one);
            end else if (i_wb_adr == ftg_pkg::REG_DIV_TWO) begin
                s_d.rdat = 32'(s_q.div_two);
            end else if (i_wb_adr == ftg_pkg::REG_INTERVAL) begin
                s_d.rdat = 32'(s_q.interval);
            end else if (i_wb_adr == ftg_pkg::REG_COUNT) begin
                s_d.rdat = 32'(s_q.count);
            end else if (i_wb_adr == ftg_pkg::REG_ROUTE) begin
                s_d.rdat = 32'(s_q.route);
            end else if (i_wb_adr == ftg_pkg::REG_STATUS) begin
                s_d.rdat = st;
            end else begin
                s_d.rdat = '0;
            end
        end

        // Both clock generators free-run at their divided rate while enabled.
        step1 = gen_step(s_q.ctrl[ftg_pkg::CTL_GEN_ONE_EN], s_q.div_one,
                         s_q.g1_cnt, s_q.g1_lvl);
        step2 = gen_step(s_q.ctrl[ftg_pkg::CTL_GEN_TWO_EN], s_q.div_two,
                         s_q.g2_cnt, s_q.g2_lvl);
        s_d.g1_lvl = step1[ftg_pkg::DIV_W];
        s_d.g1_cnt = step1[ftg_pkg::DIV_W-1:0];
        s_d.g2_lvl = step2[ftg_pkg::DIV_W];
        s_d.g2_cnt = step2[ftg_pkg::DIV_W-1:0];

        // The frame generator counts rising edges of its reference generator only.
        assoc_lvl = s_q.ctrl[ftg_pkg::CTL_FRAME_ASSC] ? s_q.g2_lvl : s_q.g1_lvl;
        assoc_evt = assoc_lvl && !s_q.assoc_prev;
        s_d.assoc_prev = assoc_lvl;
        frame_en = s_q.ctrl[ftg_pkg::CTL_FRAME_EN];
        cont     = s_q.ctrl[ftg_pkg::CTL_CONTINUOUS];

        case (s_q.state)
            ftg_pkg::FTG_IDLE: begin
                s_d.pulse_act = 1'b0;
                s_d.ivl_cnt   = '0;
                s_d.issued    = '0;
                if (frame_en) begin
                    s_d.state = ftg_pkg::FTG_RUN;
                end
            end
            ftg_pkg::FTG_RUN: begin
                if (!frame_en) begin
                    s_d.pulse_act = 1'b0;
                    s_d.state     = ftg_pkg::FTG_IDLE;
                end else if (assoc_evt) begin
                    if (s_q.ivl_cnt != '0) begin
                        s_d.pulse_act = 1'b0;
                        s_d.ivl_cnt   = s_q.ivl_cnt - 16'h0001;
                    end else if (!cont && (s_q.issued == s_q.count)) begin
                        s_d.pulse_act = 1'b0;
                        s_d.state     = ftg_pkg::FTG_DONE;
                    end else begin
                        s_d.pulse_act = 1'b1;
                        s_d.issued    = s_q.issued + 16'h0001;
                        s_d.ivl_cnt   = (s_q.interval <= 16'h0001) ? '0
                                        : s_q.interval - 16'h0001;
                    end
                end
            end
            ftg_pkg::FTG_DONE: begin
                s_d.pulse_act = 1'b0;
                if (!frame_en) begin
                    s_d.state = ftg_pkg::FTG_IDLE;
                end
            end
            default: begin
                s_d.pulse_act = 1'b0;
                s_d.state     = ftg_pkg::FTG_IDLE;
            end
        endcase

        // During an active period the output is the reference clock inverted one cycle late,
        // so the low pulse sits on that clock's high phase delayed by one cycle.
        s_d.frame_out = s_d.pulse_act ? ~s_d.assoc_prev : 1'b1;

        // Each line takes either the on-board generator or the chosen pin input.
        s_d.conv_one  = s_q.route[ftg_pkg::SIG_ONE*ftg_pkg::RT_STRIDE + ftg_pkg::RT_SRC_IO]
                        ? pin_in[ftg_pkg::SIG_ONE] : s_q.g1_lvl;
        s_d.conv_two  = s_q.route[ftg_pkg::SIG_TWO*ftg_pkg::RT_STRIDE + ftg_pkg::RT_SRC_IO]
                        ? pin_in[ftg_pkg::SIG_TWO] : s_q.g2_lvl;
        s_d.frame_sig = s_q.route[ftg_pkg::SIG_FRAME*ftg_pkg::RT_STRIDE + ftg_pkg::RT_SRC_IO]
                        ? pin_in[ftg_pkg::SIG_FRAME] : s_q.frame_out;

        // Falling edge of the active-low frame line starts a sequencer run.
        s_d.frame_prev = s_q.frame_sig;
        s_d.frame_evt  = s_q.frame_prev && !s_q.frame_sig;

        // Sequencer clock selection; phase lock to the frame line is software's job.
        s_d.ad_clk = s_q.route[ftg_pkg::RT_AD_SEL] ? s_q.conv_two : s_q.conv_one;
        s_d.da_clk = s_q.route[ftg_pkg::RT_DA_SEL] ? s_q.conv_two : s_q.conv_one;
    end

    // Single state register; the frame line idles high after reset.
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            s_q           <= '0;
            s_q.ctrl      <= ftg_pkg::CTRL_RST;
            s_q.div_one   <= ftg_pkg::DIV_RST;
            s_q.div_two   <= ftg_pkg::DIV_RST;
            s_q.interval  <= ftg_pkg::INTERVAL_RST;
            s_q.count     <= ftg_pkg::COUNT_RST;
            s_q.route     <= ftg_pkg::ROUTE_RST;
            s_q.state     <= ftg_pkg::FTG_IDLE;
            s_q.frame_out <= 1'b1;
            s_q.frame_sig <= 1'b1;
            s_q.frame_prev <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    // Generator outputs that the pins may drive; the frame one has its own pin.
    assign gen_lvl = {s_q.frame_out, s_q.g2_lvl, s_q.g1_lvl};

    // One driver/receiver pair per line and per connector side.
    for (genvar k = 0; k < ftg_pkg::SIG_N; k++) begin : g_line
        ftg_pin_io u_pin (
            .i_clk         (i_clk),
            .i_reset_n     (i_reset_n),
            .i_gen         (gen_lvl[k]),
            .i_drive_front (s_q.route[k*ftg_pkg::RT_STRIDE + ftg_pkg::RT_DRV_FRONT]),
            .i_drive_rear  (s_q.route[k*ftg_pkg::RT_STRIDE + ftg_pkg::RT_DRV_REAR]),
            .i_in_rear     (s_q.route[k*ftg_pkg::RT_STRIDE + ftg_pkg::RT_IN_REAR]),
            .i_front_in    (i_front_in[k]),
            .o_front_out   (o_front_out[k]),
            .o_front_oe    (o_front_oe[k]),
            .i_rear_in     (i_rear_in[k]),
            .o_rear_out    (o_rear_out[k]),
            .o_rear_oe     (o_rear_oe[k]),
            .o_in          (pin_in[k])
        );
    end

    // All user-side outputs come straight from the state register.
    assign o_wb_dat                   = s_q.rdat;
    assign o_wb_ack                   = s_q.ack;
    assign o_conversion_rate_line_one = s_q.conv_one;
    assign o_conversion_rate_line_two = s_q.conv_two;
    assign o_frame_start_line_n       = s_q.frame_sig;
    assign o_frame_event              = s_q.frame_evt;
    assign o_ad_conv_clk              = s_q.ad_clk;
    assign o_da_conv_clk              = s_q.da_clk;

endmodule // ftg_top

//--- tb/ftg_properties.sv
// Port-level assertions for the frame trigger generator, bound to its top module.
`timescale 1ns/1ps

module ftg_properties (
    input wire logic                        i_clk,
    input wire logic                        i_reset_n,
    input wire logic                        i_wb_cyc,
    input wire logic                        i_wb_stb,
    input wire logic [ftg_pkg::DATA_W-1:0]  o_wb_dat,
    input wire logic                        o_wb_ack,
    input wire logic [ftg_pkg::SIG_N-1:0]   o_front_oe,
    input wire logic [ftg_pkg::SIG_N-1:0]   o_rear_oe,
    input wire logic                        o_frame_start_line_n,
    input wire logic                        o_frame_event
);
    // Everything here lives in the one system clock domain.
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_reset_n);

    property p_ack_pulse;
        o_wb_ack |=> !o_wb_ack;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack held longer than one cycle");

    property p_ack_next;
        (i_wb_cyc && i_wb_stb && !o_wb_ack) |=> o_wb_ack;
    endproperty
    a_ack_next: assert property (p_ack_next) else $error("request not answered next cycle");

    property p_ack_cause;
        o_wb_ack |-> $past(i_wb_cyc && i_wb_stb);
    endproperty
    a_ack_cause: assert property (p_ack_cause) else $error("ack without a request");

    // Read data may only move together with an answer.
    property p_dat_hold;
        !o_wb_ack |=> (o_wb_ack || $stable(o_wb_dat));
    endproperty
    a_dat_hold: assert property (p_dat_hold) else $error("read data moved without ack");

    property p_event_after_fall;
        $fell(o_frame_start_line_n) |=> o_frame_event;
    endproperty
    a_event_after_fall: assert property (p_event_after_fall) else $error("no frame event");

    property p_event_cause;
        o_frame_event |-> $past(!o_frame_start_line_n);
    endproperty
    a_event_cause: assert property (p_event_cause) else $error("frame event without pulse");

    property p_event_single;
        o_frame_event |=> !o_frame_event;
    endproperty
    a_event_single: assert property (p_event_single) else $error("frame event too long");

    // Drivers must come out of reset released so no pin is fought over.
    property p_release_quiet;
        $rose(i_reset_n) |-> (o_front_oe == 3'h0 && o_rear_oe == 3'h0 && o_frame_start_line_n);
    endproperty
    a_release_quiet: assert property (p_release_quiet) else $error("pins driven at reset");
endmodule // ftg_properties

bind ftg_top ftg_properties u_ftg_properties (
    .i_clk                (i_clk),
    .i_reset_n            (i_reset_n),
    .i_wb_cyc             (i_wb_cyc),
    .i_wb_stb             (i_wb_stb),
    .o_wb_dat             (o_wb_dat),
    .o_wb_ack             (o_wb_ack),
    .o_front_oe           (o_front_oe),
    .o_rear_oe            (o_rear_oe),
    .o_frame_start_line_n (o_frame_start_line_n),
    .o_frame_event        (o_frame_event)
);

//--- tb/ftg_far_end.sv
// Model of the wiring and remote cards on the three conversion-control lines.
`timescale 1ns/1ps

module ftg_far_end (
    input  wire logic       i_clk,
    input  wire logic [2:0] i_dev_out,
    input  wire logic [2:0] i_dev_oe,
    input  wire logic [2:0] i_ext_en,
    input  wire logic [2:0] i_ext_val,
    output logic      [2:0] o_line
);
    logic flip_q = 1'b0;

    // An undriven line wanders every cycle, so a floating input never passes for a level.
    always_ff @(posedge i_clk) flip_q <= ~flip_q;

    // The device driver wins when enabled; the receiver always sees the line.
    always_comb
        for (int k = 0; k < 3; k++)
            o_line[k] = i_dev_oe[k] ? i_dev_out[k] : (i_ext_en[k] ? i_ext_val[k] : flip_q);
endmodule // ftg_far_end

//--- tb/ftg_tb_top.sv
// Self-checking testbench for the frame trigger generator.
`timescale 1ns/1ps

module ftg_tb_top;
    logic        i_clk = 0, i_reset_n = 0, cyc = 0, stb = 0, we = 0;
    logic [7:0]  adr = '0;
    logic [3:0]  sel = 4'hF;
    logic [31:0] wdat = '0, rd;
    logic [2:0]  f_in, r_in, f_out, f_oe, r_out, r_oe, ext_val = '0, ext_en = '0;
    logic [31:0] o_dat;
    logic        ack, line_one, line_two, frame_n, frame_ev, ad_clk, da_clk, prev_n = 1, prev_one;
    int          n_errors = 0, checks_done = 0, n_pulse = 0, gap = 0, tick = 0, last_fall = 0;
    int          n_tog = 0, n_ev = 0, n_low = 0;
    logic [7:0]  ra [7] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h20};
    logic [31:0] rv [7] = '{32'h0, 32'h64, 32'h64, 32'h4, 32'h1, 32'h0, 32'h0};

    always #2.5 i_clk = ~i_clk;

    ftg_top i_dut (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_wb_cyc(cyc), .i_wb_stb(stb),
        .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat), .o_wb_dat(o_dat),
        .o_wb_ack(ack), .i_front_in(f_in), .o_front_out(f_out), .o_front_oe(f_oe),
        .i_rear_in(r_in), .o_rear_out(r_out), .o_rear_oe(r_oe),
        .o_conversion_rate_line_one(line_one), .o_conversion_rate_line_two(line_two),
        .o_frame_start_line_n(frame_n), .o_frame_event(frame_ev),
        .o_ad_conv_clk(ad_clk), .o_da_conv_clk(da_clk));
    ftg_far_end u_front (.i_clk(i_clk), .i_dev_out(f_out), .i_dev_oe(f_oe),
        .i_ext_en(3'h0), .i_ext_val(3'h0), .o_line(f_in));
    ftg_far_end u_rear (.i_clk(i_clk), .i_dev_out(r_out), .i_dev_oe(r_oe),
        .i_ext_en(ext_en), .i_ext_val(ext_val), .o_line(r_in));

    // Count frame pulses, their spacing and line one toggles from pre-edge samples.
    always @(posedge i_clk) begin
        tick++;
        if (prev_n && !frame_n) begin
            n_pulse++;
            gap = tick - last_fall;
            last_fall = tick;
        end
        if (prev_one !== line_one) n_tog++;
        if (frame_ev === 1'b1) n_ev++;
        if (frame_n === 1'b0) n_low++;
        prev_n = frame_n;
        prev_one = line_one;
    end

    task automatic end_of_test();
        $display("counts: checks=%0d errors=%0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    // One classic cycle; the request stands until ack is sampled high.
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge i_clk);
        cyc <= 1; stb <= 1; we <= w; adr <= a; wdat <= d;
        for (n = 0; n < 20; n++) begin
            @(posedge i_clk);
            if (ack === 1'b1) break;
        end
        if (n == 20) begin
            n_errors++;
            end_of_test();
        end else begin
            rd = o_dat;
            cyc <= 0;
            stb <= 0;
        end
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Hang guard: far beyond the longest scenario.
    initial begin
        repeat (20000) @(posedge i_clk);
        n_errors++;
        end_of_test();
    end

    initial begin
        repeat (2) @(posedge i_clk);
        i_reset_n <= 1;
        wb(1, 8'h20, 32'hFFFF_FFFF);
        for (int k = 0; k < 7; k++) begin
            wb(0, ra[k], 32'h0);
            chk(rd, rv[k]);
        end
        $display("test reset_values done");
        // Counted mode twice: a re-enable must give a fresh run. reference is on-board.
        wb(1, 8'h04, 32'h1); wb(1, 8'h0C, 32'h2); wb(1, 8'h10, 32'h2);
        for (int r = 0; r < 2; r++) begin
            wb(1, 8'h00, 32'h0);
            n_pulse = 0;
            n_ev = 0;
            n_low = 0;
            wb(1, 8'h00, 32'h05);
            repeat (60) @(posedge i_clk);
            chk(n_pulse, 2);
            chk(gap, 4);
            chk(n_ev, 2);
            chk(n_low, 2);
            wb(0, 8'h18, 32'h0);
            if (r == 0) chk(rd & 32'hFFFF_0003, 32'h0002_0002);
        end
        $display("test counted done");
        // Continuous run referenced to generator two: half period 2, interval 3.
        wb(1, 8'h00, 32'h0); wb(1, 8'h08, 32'h2); wb(1, 8'h0C, 32'h3);
        wb(1, 8'h00, 32'h1E);
        n_pulse = 0;
        repeat (100) @(posedge i_clk);
        chk(gap, 12);
        chk(n_pulse > 5, 1);
        wb(1, 8'h00, 32'h0);
        // A pulse launched on the stopping edge may still reach the line; let it pass.
        repeat (4) @(posedge i_clk);
        n_pulse = 0;
        repeat (40) @(posedge i_clk);
        chk(n_pulse, 0);
        $display("test continuous done");
        // Line one from its own driven front pin, line two from the rear pin.
        ext_en <= 3'b010; ext_val <= 3'b010;
        wb(1, 8'h00, 32'h1); wb(1, 8'h14, 32'h1035);
        repeat (8) @(posedge i_clk);
        chk(f_oe, 3'h1);
        chk(r_oe, 3'h0);
        chk(line_two, 1);
        chk(ad_clk, 1);
        ext_val <= 3'b000;
        n_tog = 0;
        repeat (16) @(posedge i_clk);
        chk(line_two, 0);
        chk(ad_clk, 0);
        chk(n_tog > 4, 1);
        wb(1, 8'h14, 32'h804);
        repeat (4) @(posedge i_clk);
        chk(f_oe, 3'h1);
        chk(r_oe, 3'h4);
        chk(r_out[2], 1);
        chk(f_out[2:1], 2'b10);
        chk(da_clk, ad_clk);
        $display("test routing done");
        end_of_test();
    end
endmodule // ftg_tb_top
